//--- design/gpio_port.sv
// six-bit bidirectional port with serial and timer overrides
`timescale 1ns/10ps

module gpio_port #(
   parameter int WIDTH = 6
) (
   input wire logic clock,
   input wire logic resetn,
   input wire gpio_port_pkg::io_request_type io_req,
   output logic [7:0] io_rdata,
   input wire gpio_port_pkg::serial_side_type serial_side,
   input wire logic compare_enable,
   input wire logic compare_value,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe_n,
   output logic [WIDTH-1:0] pin_pullup,
   output logic [WIDTH-1:0] pin_level
);
   logic [WIDTH-1:0] latch_reg;
   logic [WIDTH-1:0] direction_reg;
   logic [WIDTH-1:0] sync_first_reg;
   logic [WIDTH-1:0] sense_reg;
   logic [7:0] rdata_reg;
   logic [WIDTH-1:0] force_input;
   logic [WIDTH-1:0] drive_value;
   logic [WIDTH-1:0] direction_eff;
   logic [WIDTH-1:0] bit_mask;
   logic bit_in_range;
   logic serial_slave;
   logic serial_master;

   // =====================================
   // register writes
   assign bit_in_range = (io_req.bit_index < 3'(WIDTH));
   assign bit_mask = bit_in_range ? (WIDTH'(1) << io_req.bit_index) : '0;

   always_ff @(posedge clock) begin
      if (!resetn) begin
         latch_reg <= gpio_port_pkg::LATCH_RESET;
      end else if (io_req.addr == gpio_port_pkg::LATCH_ADDR) begin
         if (io_req.write) begin
            latch_reg <= io_req.wdata[WIDTH-1:0];
         end else if (io_req.bit_set) begin
            latch_reg <= latch_reg | bit_mask;
         end else if (io_req.bit_clear) begin
            latch_reg <= latch_reg & ~bit_mask;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         direction_reg <= gpio_port_pkg::DIRECTION_RESET;
      end else if (io_req.addr == gpio_port_pkg::DIRECTION_ADDR) begin
         if (io_req.write) begin
            direction_reg <= io_req.wdata[WIDTH-1:0];
         end else if (io_req.bit_set) begin
            direction_reg <= direction_reg | bit_mask;
         end else if (io_req.bit_clear) begin
            direction_reg <= direction_reg & ~bit_mask;
         end
      end
   end

   // =====================================
   // pin sampling, two stages against metastability
   always_ff @(posedge clock) begin
      if (!resetn) begin
         sync_first_reg <= gpio_port_pkg::SENSE_RESET;
         sense_reg <= gpio_port_pkg::SENSE_RESET;
      end else begin
         sync_first_reg <= pin_in;
         sense_reg <= sync_first_reg;
      end
   end
   assign pin_level = sense_reg;

   // =====================================
   // read port, one cycle after the strobe
   always_ff @(posedge clock) begin
      if (!resetn) begin
         rdata_reg <= gpio_port_pkg::RDATA_RESET;
      end else if (io_req.read) begin
         unique case (io_req.addr)
            gpio_port_pkg::LATCH_ADDR: rdata_reg <= 8'(latch_reg);
            gpio_port_pkg::DIRECTION_ADDR: rdata_reg <= 8'(direction_reg);
            gpio_port_pkg::PIN_SENSE_ADDR: rdata_reg <= 8'(sense_reg);
            default: rdata_reg <= 8'h00;
         endcase
      end
   end
   assign io_rdata = rdata_reg;

   // =====================================
   // alternate-function overrides
   assign serial_slave = serial_side.enable & ~serial_side.master;
   assign serial_master = serial_side.enable & serial_side.master;

   always_comb begin
      force_input = '0;
      force_input[gpio_port_pkg::SCK_BIT] = serial_slave;
      force_input[gpio_port_pkg::MISO_BIT] = serial_master;
      force_input[gpio_port_pkg::MOSI_BIT] = serial_slave;
      force_input[gpio_port_pkg::SELECT_BIT] = serial_slave;
      drive_value = latch_reg;
      if (compare_enable) begin
         drive_value[gpio_port_pkg::COMPARE_BIT] = compare_value;
      end
      if (serial_master) begin
         drive_value[gpio_port_pkg::SCK_BIT] = serial_side.sck_out;
         drive_value[gpio_port_pkg::MOSI_BIT] = serial_side.mosi_out;
      end
      if (serial_slave) begin
         drive_value[gpio_port_pkg::MISO_BIT] = serial_side.miso_out;
      end
   end

   // =====================================
   // pad control; reset gates the enables without waiting for an edge,
   // so pins float even with the clock stopped
   assign direction_eff = direction_reg & ~force_input;
   assign pin_out = drive_value;
   assign pin_oe_n = ~(direction_eff & {WIDTH{resetn}});
   assign pin_pullup = ~direction_eff & latch_reg & {WIDTH{resetn}};

   // =====================================
   // checks
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);

   chk_plain_output_drive: assert property (
      direction_reg[0] |-> !pin_oe_n[0] && pin_out[0] == latch_reg[0])
      else $error("output pin not driving its latch bit");
   chk_pullup_input_only: assert property (
      pin_pullup[0] |-> !direction_reg[0] && latch_reg[0])
      else $error("pull-up on without input and latch one");
   chk_reset_tristate: assert property (
      @(posedge clock) disable iff (1'b0) !resetn |-> &pin_oe_n && pin_pullup == '0)
      else $error("pin driven during reset");
   chk_latch_readback: assert property (
      io_req.read && io_req.addr == gpio_port_pkg::LATCH_ADDR && !io_req.write
      |=> io_rdata == 8'($past(latch_reg)))
      else $error("latch read returned wrong value");
   chk_sense_write_ignored: assert property (
      io_req.addr == gpio_port_pkg::PIN_SENSE_ADDR |=> $stable(latch_reg) && $stable(direction_reg))
      else $error("write to sense location changed state");
   chk_upper_read_zero: assert property (
      io_rdata[7:6] == 2'b00)
      else $error("upper read bits not zero");
   chk_single_bit_set: assert property (
      io_req.addr == gpio_port_pkg::DIRECTION_ADDR && !io_req.write && io_req.bit_set
      && io_req.bit_index == 3'd2 |=> direction_reg == ($past(direction_reg) | 6'h04))
      else $error("bit set disturbed other pins");
   chk_slave_clock_input: assert property (
      serial_side.enable && !serial_side.master |-> pin_oe_n[5] && pin_oe_n[3] && pin_oe_n[2])
      else $error("slave pins not forced to input");
   chk_master_miso_input: assert property (
      serial_side.enable && serial_side.master |-> pin_oe_n[4])
      else $error("master-in pin not forced to input");
   chk_master_mosi_follow: assert property (
      serial_side.enable && serial_side.master |-> pin_oe_n[3] == !direction_reg[3])
      else $error("master-out direction not following its bit");
   chk_forced_pullup: assert property (
      serial_side.enable && !serial_side.master && latch_reg[5] |-> pin_pullup[5])
      else $error("forced input lost its pull-up");
   chk_select_slave: assert property (
      serial_side.enable && !serial_side.master && direction_reg[2] |-> pin_oe_n[2])
      else $error("select pin driven as slave");
   chk_compare_drive: assert property (
      compare_enable && direction_reg[1] |-> !pin_oe_n[1] && pin_out[1] == compare_value)
      else $error("compare output not on its pin");
   chk_sense_two_stage: assert property (
      resetn [*3] |-> pin_level == $past(pin_in, 2))
      else $error("sensed level not two cycles behind pin");
   chk_upper_bit_op: assert property (
      !io_req.write && (io_req.bit_set || io_req.bit_clear) && io_req.bit_index > 3'd5
      |=> $stable(latch_reg) && $stable(direction_reg))
      else $error("upper bit operation changed state");
   chk_direction_readback: assert property (
      io_req.read && io_req.addr == gpio_port_pkg::DIRECTION_ADDR
      |=> io_rdata == 8'($past(direction_reg)))
      else $error("direction read returned wrong value");
   chk_sense_readback: assert property (
      io_req.read && io_req.addr == gpio_port_pkg::PIN_SENSE_ADDR
      |=> io_rdata == 8'($past(sense_reg)))
      else $error("sense read returned wrong value");
   chk_single_bit_clear: assert property (
      io_req.addr == gpio_port_pkg::LATCH_ADDR && !io_req.write && !io_req.bit_set
      && io_req.bit_clear && io_req.bit_index == 3'd3
      |=> latch_reg == ($past(latch_reg) & 6'h37))
      else $error("bit clear disturbed other pins");
   chk_slave_miso_follow: assert property (
      serial_side.enable && !serial_side.master |-> pin_oe_n[4] == !direction_reg[4])
      else $error("slave data-out direction not following its bit");
   // serial drive values reach a pad only where its direction bit allows
   chk_master_clock_drive: assert property (
      serial_side.enable && serial_side.master && direction_reg[5]
      |-> !pin_oe_n[5] && pin_out[5] == serial_side.sck_out)
      else $error("serial clock not on its pin");
   chk_slave_data_drive: assert property (
      serial_side.enable && !serial_side.master && direction_reg[4]
      |-> !pin_oe_n[4] && pin_out[4] == serial_side.miso_out)
      else $error("slave data out not on its pin");

   cov_pullup_input: cover property (pin_pullup[3] && !pin_oe_n[0]);
   cov_serial_master: cover property (serial_side.enable && serial_side.master && !pin_oe_n[5]);
   cov_serial_slave: cover property (serial_side.enable && !serial_side.master && pin_pullup[5]);
   cov_sense_read: cover property (io_req.read && io_req.addr == gpio_port_pkg::PIN_SENSE_ADDR);
   cov_bit_clear: cover property (io_req.bit_clear && io_req.addr == gpio_port_pkg::LATCH_ADDR);
endmodule : gpio_port

//--- design/gpio_port_pkg.sv
// constants and carrier types for the six-bit port
package gpio_port_pkg;
   // =====================================
   // i/o space locations
   localparam logic [5:0] PIN_SENSE_ADDR = 6'h16;
   localparam logic [5:0] DIRECTION_ADDR = 6'h17;
   localparam logic [5:0] LATCH_ADDR = 6'h18;
   // =====================================
   // reset values
   localparam logic [5:0] LATCH_RESET = 6'h00;
   localparam logic [5:0] DIRECTION_RESET = 6'h00;
   localparam logic [5:0] SENSE_RESET = 6'h00;
   localparam logic [7:0] RDATA_RESET = 8'h00;
   // =====================================
   // pin positions of the alternate functions
   localparam int CAPTURE_BIT = 0;
   localparam int COMPARE_BIT = 1;
   localparam int SELECT_BIT = 2;
   localparam int MOSI_BIT = 3;
   localparam int MISO_BIT = 4;
   localparam int SCK_BIT = 5;
   // =====================================
   // carriers
   typedef struct packed {
      logic [5:0] addr;
      logic write;
      logic read;
      logic bit_set;
      logic bit_clear;
      logic [2:0] bit_index;
      logic [7:0] wdata;
   } io_request_type;

   typedef struct packed {
      logic enable;
      logic master;
      logic sck_out;
      logic mosi_out;
      logic miso_out;
   } serial_side_type;
endpackage : gpio_port_pkg

//--- test/board_model.sv
// board-side model of the six pads
`timescale 1ns/10ps
module board_model (
   input wire logic clock,
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe_n,
   input wire logic [5:0] pin_pullup,
   input wire logic [5:0] ext_value,
   input wire logic [5:0] ext_en,
   output logic [5:0] pin_in
);
   logic [5:0] float_reg = 6'h00;
   // a floating pad wanders so a stale level never passes
   always @(posedge clock) float_reg <= ~float_reg;
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
         else if (ext_en[i]) pin_in[i] = ext_value[i];
         else if (pin_pullup[i]) pin_in[i] = 1'b1;
         else pin_in[i] = float_reg[i];
      end
   end
endmodule : board_model

//--- test/six_bit_gpio_port_with_spi_override_tb_top.sv
// self-checking bench for the six-bit port
`timescale 1ns/10ps
module six_bit_gpio_port_with_spi_override_tb_top;
   localparam logic [5:0] SA = gpio_port_pkg::PIN_SENSE_ADDR;
   localparam logic [5:0] DA = gpio_port_pkg::DIRECTION_ADDR;
   localparam logic [5:0] LA = gpio_port_pkg::LATCH_ADDR;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   gpio_port_pkg::io_request_type io_req = '0;
   gpio_port_pkg::serial_side_type serial_side = '0;
   logic compare_enable = 1'b0;
   logic compare_value = 1'b0;
   logic [7:0] io_rdata;
   logic [5:0] pin_in, pin_out, pin_oe_n, pin_pullup, pin_level;
   logic [5:0] ext_value = 6'h00;
   logic [5:0] ext_en = 6'h3f;
   logic [7:0] exp_q[$];
   logic rd_pend = 1'b0;
   logic [5:0] d, l;
   int err_count = 0;
   int n_tests = 0;
   // ==========================================
   // structure
   initial forever #5 clock = ~clock;
   gpio_port #(.WIDTH(6)) u_dut (.clock(clock), .resetn(resetn), .io_req(io_req),
      .io_rdata(io_rdata), .serial_side(serial_side), .compare_enable(compare_enable),
      .compare_value(compare_value), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .pin_pullup(pin_pullup), .pin_level(pin_level));
   board_model u_board (.clock(clock), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pin_pullup(pin_pullup), .ext_value(ext_value), .ext_en(ext_en), .pin_in(pin_in));
   // ==========================================
   // tasks
   task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic access(logic [5:0] a, logic w, logic s, logic c, logic r, logic [2:0] i,
      logic [7:0] wd);
      @(negedge clock);
      io_req = '{addr: a, write: w, read: r, bit_set: s, bit_clear: c, bit_index: i, wdata: wd};
      @(negedge clock);
      io_req = '0;
   endtask : access
   task automatic rd(logic [5:0] a, logic [7:0] e);
      exp_q.push_back(e);
      access(a, 1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 8'h00);
   endtask : rd
   task automatic pads(logic [5:0] eo, logic [5:0] ep);
      chk("pin_oe_n", {2'b00, pin_oe_n}, {2'b00, eo});
      chk("pin_pullup", {2'b00, pin_pullup}, {2'b00, ep});
   endtask : pads
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_sim
   // ==========================================
   // read monitor: answer lands one edge after the read
   always @(posedge clock) rd_pend <= resetn & io_req.read;
   always @(negedge clock) if (rd_pend) chk("io_rdata", io_rdata, exp_q.pop_front());
   initial begin
      #20000;
      err_count++;
      end_sim;
   end
   initial begin
      void'($urandom(55129));
      #1 pads(6'h3f, 6'h00);
      repeat (16) @(negedge clock);
      resetn = 1'b1;
      rd(LA, 8'h00);
      rd(DA, 8'h00);
      $display("test reset done");
      for (int k = 0; k < 8; k++) begin
         d = 6'($urandom);
         l = 6'($urandom);
         ext_value = 6'($urandom);
         access(LA, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0, {2'b11, l});
         access(DA, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0, {2'b10, d});
         access(SA, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 8'hff);
         pads(~d, ~d & l);
         chk("pin_out", {2'b00, pin_out & d}, {2'b00, l & d});
         rd(LA, {2'b00, l});
         rd(DA, {2'b00, d});
         rd(SA, {2'b00, (l & d) | (ext_value & ~d)});
         chk("pin_level", {2'b00, pin_level}, {2'b00, (l & d) | (ext_value & ~d)});
      end
      $display("test latch direction sense done");
      for (int i = 0; i < 6; i++) begin
         access(DA, 1'b0, 1'b1, 1'b0, 1'b0, 3'(i), 8'h00);
         access(LA, 1'b0, 1'b0, 1'b1, 1'b0, 3'(i), 8'h00);
         d[i] = 1'b1;
         l[i] = 1'b0;
         rd(DA, {2'b00, d});
         rd(LA, {2'b00, l});
      end
      access(LA, 1'b0, 1'b1, 1'b0, 1'b0, 3'h6, 8'h00);
      rd(LA, {2'b00, l});
      $display("test bit set clear done");
      // software sets direction and latch before the alternate use
      access(LA, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 8'h3f);
      for (int m = 0; m < 2; m++) begin
         @(negedge clock);
         serial_side = '{enable: 1'b1, master: m[0], sck_out: 1'b0, mosi_out: 1'b0,
            miso_out: 1'b0};
         #1 pads(m ? 6'h10 : 6'h2c, m ? 6'h10 : 6'h2c);
         chk("serial pin_out", {2'b00, pin_out}, m ? 8'h17 : 8'h2f);
      end
      @(negedge clock);
      serial_side = '0;
      compare_enable = 1'b1;
      #1 chk("compare pin", {7'h00, pin_out[1]}, 8'h00);
      $display("test alternate functions done");
      @(negedge clock);
      resetn = 1'b0;
      #1 pads(6'h3f, 6'h00);
      @(negedge clock);
      resetn = 1'b1;
      rd(DA, 8'h00);
      $display("test mid-run reset done");
      access(LA, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0, 8'h3f);
      ext_en = 6'h00;
      #1 pads(6'h3f, 6'h3f);
      repeat (2) @(negedge clock);
      rd(SA, 8'h3f);
      $display("test pull-up done");
      repeat (3) @(negedge clock);
      end_sim;
   end
endmodule : six_bit_gpio_port_with_spi_override_tb_top
